/* File: common/touch_cfg_regs.vh */
// register offsets, reset values, field positions and timing constants
// assumes a 250 MHz system clock and an smbus engine delivering byte accesses
//
// Functional notes
// (R1) gain code halves multiplier, 128x down to 1x
// (R2) channel delta scaled by gain before threshold
// (R3) baseline view scale doubles per code
// (R4) baseline scale affects presentation only
// (R5) one gain setting for all buttons
// (R6) timeout bit clear: no timeout, no idle
// (R7) timeout bit set: 30ms low, 150us idle
// (R8) format clear: slider reports touched sensor
// (R9) format set: volumetric data, register writable
// (R10) digital filter on: discard noise-band samples
// (R11) digital filter off: sub-threshold samples recalibrate
// (R12) analog filter on: noisy channel delta zero
// (R13) analog filter off: noise never blocks touch
// (R14) ungrouped long press restarts recalibration
// (R15) grouped long press restarts recalibration
// (R16) hold recal disabled: hold indefinitely
// (R17) button repeat: one or repeated interrupts
// (R18) group repeat: repeat while pressed
// (R19) delta saturates 7fh positive, ffh negative
// (R20) repeat interval (code + 1) times 35ms
// (R21) baseline codes above 8 act as 256x
`ifndef TOUCH_CFG_REGS_VH
`define TOUCH_CFG_REGS_VH

// =====================================================
// register map
`define ADDR_GAIN       8'h1f
`define ADDR_CFG        8'h20
`define ADDR_SLIDER     8'h06
`define RST_GAIN        8'h2f
`define RST_CFG         8'h29
`define RST_BYTE        8'h00

// =====================================================
// fields
`define GAIN_HI         6
`define GAIN_LO         4
`define BASE_HI         3
`define BASE_LO         0
`define CFG_TIMEOUT     7
`define CFG_SLIDER_FMT  6
`define CFG_DIG_OFF     5
`define CFG_ANA_OFF     4
`define CFG_UHOLD_EN    3
`define CFG_BRPT_EN     2
`define CFG_GHOLD_EN    1
`define CFG_GRPT_EN     0
`define GAIN_MAX_CODE   3'h7
`define BASE_MAX_CODE   4'h8
`define DELTA_SAT_POS   8'h7f
`define DELTA_SAT_NEG   8'hff
`define DELTA_ZERO      8'h00

// =====================================================
// timing
`define CLK_KHZ         250000
`define CLK_MHZ         250
`define BUS_LOW_MS      30
`define BUS_IDLE_US     150
`define RPT_STEP_MS     35

`endif

/* File: hdl/delta_scaler.v */
// one channel: gain scaling, noise filtering, saturation and threshold compare
// assumes raw deltas and thresholds are stable for the sample they belong to
`include "touch_cfg_regs.vh"

module delta_scaler #(
  parameter RAW_W = 16
) (
  input  wire             clk_i,
  input  wire             reset_n_i,
  input  wire [RAW_W-1:0] raw_delta_i,
  input  wire [2:0]       gain_shift_i,
  input  wire [7:0]       touch_thr_i,
  input  wire [7:0]       noise_thr_i,
  input  wire             lf_noise_i,
  input  wire             ana_off_i,
  input  wire             dig_off_i,
  output reg  [7:0]       delta_o,
  output reg              touch_o,
  output reg              recal_ok_o
);

  localparam SW = RAW_W + 8;

  reg signed [SW-1:0] scaled;
  reg        [7:0]    delta_d;
  reg                 touch_d;

  always @* begin
    scaled = $signed({{8{raw_delta_i[RAW_W-1]}}, raw_delta_i}) <<< gain_shift_i; // R2
    if (lf_noise_i && !ana_off_i) begin // R12 R13
      delta_d = `DELTA_ZERO;
    end else if (scaled < 0) begin
      delta_d = `DELTA_SAT_NEG; // R19
    end else if (scaled > $signed({{(SW-8){1'b0}}, `DELTA_SAT_POS})) begin
      delta_d = `DELTA_SAT_POS; // R19
    end else begin
      delta_d = scaled[7:0];
    end
    touch_d = !delta_d[7] && (delta_d > touch_thr_i);
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      delta_o    <= `DELTA_ZERO;
      touch_o    <= 1'b0;
      recal_ok_o <= 1'b0;
    end else begin
      delta_o    <= delta_d;
      touch_o    <= touch_d;
      // noise-band samples kept out of recalibration unless filter off
      recal_ok_o <= !touch_d && (dig_off_i || delta_d[7] || delta_d <= noise_thr_i); // R10 R11
    end
  end

endmodule // delta_scaler

/* File: hdl/hold_timer.v */
// press timing: interrupt on touch, auto-repeat, maximum-duration recalibration
// assumes press_i is a clean level from the detection logic
`include "touch_cfg_regs.vh"

module hold_timer #(
  parameter CYC_PER_MS = `CLK_KHZ
) (
  input  wire       clk_i,
  input  wire       reset_n_i,
  input  wire       press_i,
  input  wire       hold_en_i,
  input  wire       rpt_en_i,
  input  wire [3:0] max_code_i,
  input  wire [3:0] rate_code_i,
  output reg        irq_o,
  output reg        recal_o
);

  reg [31:0] pre_q;
  reg [13:0] hold_ms_q;
  reg [9:0]  rpt_ms_q;
  reg        press_q;
  reg        recal_done_q;
  reg [13:0] max_ms;
  wire       ms_tick;
  wire [31:0] rpt_full;
  wire [9:0] rpt_ms;

  assign ms_tick  = (pre_q == CYC_PER_MS - 1);
  // 16 x 35 ms fits in ten bits
  assign rpt_full = ({28'h0, rate_code_i} + 32'h1) * `RPT_STEP_MS; // R20
  assign rpt_ms   = rpt_full[9:0];

  always @* begin
    case (max_code_i)
      4'h0:    max_ms = 14'd560;
      4'h1:    max_ms = 14'd840;
      4'h2:    max_ms = 14'd1120;
      4'h3:    max_ms = 14'd1400;
      4'h4:    max_ms = 14'd1680;
      4'h5:    max_ms = 14'd2240;
      4'h6:    max_ms = 14'd2800;
      4'h7:    max_ms = 14'd3360;
      4'h8:    max_ms = 14'd3920;
      4'h9:    max_ms = 14'd4480;
      4'ha:    max_ms = 14'd5600;
      4'hb:    max_ms = 14'd6720;
      4'hc:    max_ms = 14'd7840;
      4'hd:    max_ms = 14'd8906;
      4'he:    max_ms = 14'd10080;
      default: max_ms = 14'd11200;
    endcase
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      pre_q        <= 32'h0;
      hold_ms_q    <= 14'h0;
      rpt_ms_q     <= 10'h0;
      press_q      <= 1'b0;
      recal_done_q <= 1'b0;
      irq_o        <= 1'b0;
      recal_o      <= 1'b0;
    end else begin
      press_q <= press_i;
      irq_o   <= 1'b0;
      recal_o <= 1'b0;
      if (!press_i) begin
        pre_q        <= 32'h0;
        hold_ms_q    <= 14'h0;
        rpt_ms_q     <= 10'h0;
        recal_done_q <= 1'b0;
      end else begin
        pre_q <= ms_tick ? 32'h0 : pre_q + 32'h1;
        if (!press_q) begin
          irq_o <= 1'b1; // R17 R18
        end
        if (ms_tick) begin
          if (hold_ms_q != 14'h3fff) begin
            hold_ms_q <= hold_ms_q + 14'h1;
          end
          if (rpt_ms_q + 10'h1 >= rpt_ms) begin
            rpt_ms_q <= 10'h0;
            irq_o    <= rpt_en_i; // R17 R18
          end else begin
            rpt_ms_q <= rpt_ms_q + 10'h1;
          end
          // one restart per press once the limit passes; disabled: none
          if (hold_en_i && !recal_done_q && hold_ms_q >= max_ms) begin // R14 R15 R16
            recal_o      <= 1'b1;
            recal_done_q <= 1'b1;
          end
        end
      end
    end
  end

endmodule // hold_timer

/* File: hdl/touch_cfg_top.v */
// sensitivity and global configuration registers with the logic they steer
// assumes an smbus engine hands over byte register accesses on reg_* ports
`include "touch_cfg_regs.vh"

module touch_cfg_top #(
  parameter NCH         = 7,
  parameter RAW_W       = 16,
  parameter CYC_PER_MS  = `CLK_KHZ,
  parameter BUS_LOW_CYC = `BUS_LOW_MS * `CLK_KHZ,
  parameter BUS_IDLE_CYC = `BUS_IDLE_US * `CLK_MHZ
) (
  input  wire                 clk_i,
  input  wire                 reset_n_i,
  // register access from the serial engine
  input  wire [7:0]           reg_addr_i,
  input  wire                 reg_wr_i,
  input  wire [7:0]           reg_wdata_i,
  input  wire                 reg_rd_i,
  output reg  [7:0]           reg_rdata_o,
  // serial bus line levels
  input  wire                 scl_i,
  input  wire                 sda_i,
  output reg                  bus_timeout_o,
  output reg                  bus_idle_reset_o,
  // sensing data
  input  wire [NCH*RAW_W-1:0] raw_delta_i,
  input  wire [NCH-1:0]       lf_noise_i,
  input  wire [7:0]           touch_thr_i,
  input  wire [7:0]           noise_thr_i,
  output wire [NCH*8-1:0]     delta_o,
  output wire [NCH-1:0]       touch_o,
  output wire [NCH-1:0]       recal_ok_o,
  input  wire [15:0]          base_count_i,
  output reg  [15:0]          base_view_o,
  // slider
  input  wire [6:0]           slider_pos_i,
  output reg  [6:0]           slider_volume_o,
  input  wire                 group_press_i,
  // timing codes held in neighbouring registers
  input  wire [3:0]           ungrouped_max_hold_time_i,
  input  wire [3:0]           grouped_max_hold_time_i,
  input  wire [3:0]           button_rate_i,
  input  wire [3:0]           group_rate_i,
  output wire                 button_irq_o,
  output wire                 group_irq_o,
  output wire                 ungrouped_recal_o,
  output wire                 grouped_recal_o
);

  // =====================================================
  // registers
  reg  [7:0]  gain_q;
  reg  [7:0]  cfg_q;
  reg  [7:0]  rdata_d;
  reg  [3:0]  base_code;
  wire [2:0]  gain_shift;
  wire        slider_output_format;
  wire        digital_noise_filter_off;
  wire        analog_noise_filter_off;
  wire        ungrouped_hold_recal_enable;
  wire        grouped_hold_recal_enable;
  wire        button_repeat_enable;
  wire        group_repeat_enable;
  wire        bus_timeout_enable;

  assign bus_timeout_enable          = cfg_q[`CFG_TIMEOUT];
  assign slider_output_format        = cfg_q[`CFG_SLIDER_FMT];
  assign digital_noise_filter_off    = cfg_q[`CFG_DIG_OFF];
  assign analog_noise_filter_off     = cfg_q[`CFG_ANA_OFF];
  assign ungrouped_hold_recal_enable = cfg_q[`CFG_UHOLD_EN];
  assign button_repeat_enable        = cfg_q[`CFG_BRPT_EN];
  assign grouped_hold_recal_enable   = cfg_q[`CFG_GHOLD_EN];
  assign group_repeat_enable         = cfg_q[`CFG_GRPT_EN];

  // code 0 is 128x (shift 7), code 7 is 1x (shift 0)
  assign gain_shift = `GAIN_MAX_CODE - gain_q[`GAIN_HI:`GAIN_LO]; // R1

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      gain_q          <= `RST_GAIN;
      cfg_q           <= `RST_CFG;
      slider_volume_o <= 7'h00;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `ADDR_GAIN: gain_q <= reg_wdata_i;
        `ADDR_CFG:  cfg_q  <= reg_wdata_i;
        `ADDR_SLIDER: begin
          if (slider_output_format) begin // R9
            slider_volume_o <= reg_wdata_i[6:0];
          end
        end
        default: ;
      endcase
    end
  end

  always @* begin
    case (reg_addr_i)
      `ADDR_GAIN:   rdata_d = {1'b0, gain_q[6:0]};
      `ADDR_CFG:    rdata_d = cfg_q;
      `ADDR_SLIDER: rdata_d = slider_output_format ?
                              {1'b0, slider_volume_o} : {1'b0, slider_pos_i}; // R8 R9
      default:      rdata_d = `RST_BYTE;
    endcase
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= `RST_BYTE;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_d;
    end
  end

  // =====================================================
  // baseline presentation, independent of detection
  always @* begin
    if (gain_q[`BASE_HI:`BASE_LO] > `BASE_MAX_CODE) begin
      base_code = `BASE_MAX_CODE; // R21
    end else begin
      base_code = gain_q[`BASE_HI:`BASE_LO]; // R3
    end
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      base_view_o <= 16'h0000;
    end else begin
      base_view_o <= base_count_i >> base_code; // R3 R4
    end
  end

  // =====================================================
  // per-channel delta path, one gain for all
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      delta_scaler #(
        .RAW_W (RAW_W)
      ) u_scaler (
        .clk_i        (clk_i),
        .reset_n_i    (reset_n_i),
        .raw_delta_i  (raw_delta_i[g*RAW_W +: RAW_W]),
        .gain_shift_i (gain_shift), // R5
        .touch_thr_i  (touch_thr_i),
        .noise_thr_i  (noise_thr_i),
        .lf_noise_i   (lf_noise_i[g]),
        .ana_off_i    (analog_noise_filter_off),
        .dig_off_i    (digital_noise_filter_off),
        .delta_o      (delta_o[g*8 +: 8]),
        .touch_o      (touch_o[g]),
        .recal_ok_o   (recal_ok_o[g])
      );
    end
  endgenerate

  // =====================================================
  // press timing for ungrouped buttons and the group
  hold_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_button_timer (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .press_i     (|touch_o),
    .hold_en_i   (ungrouped_hold_recal_enable), // R14 R16
    .rpt_en_i    (button_repeat_enable), // R17
    .max_code_i  (ungrouped_max_hold_time_i),
    .rate_code_i (button_rate_i),
    .irq_o       (button_irq_o),
    .recal_o     (ungrouped_recal_o)
  );

  hold_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_group_timer (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .press_i     (group_press_i),
    .hold_en_i   (grouped_hold_recal_enable), // R15 R16
    .rpt_en_i    (group_repeat_enable), // R18
    .max_code_i  (grouped_max_hold_time_i),
    .rate_code_i (group_rate_i),
    .irq_o       (group_irq_o),
    .recal_o     (grouped_recal_o)
  );

  // =====================================================
  // serial bus clock-low timeout and idle detection
  reg [31:0] low_cnt_q;
  reg [31:0] idle_cnt_q;

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      low_cnt_q        <= 32'h0;
      idle_cnt_q       <= 32'h0;
      bus_timeout_o    <= 1'b0;
      bus_idle_reset_o <= 1'b0;
    end else begin
      bus_timeout_o    <= 1'b0;
      bus_idle_reset_o <= 1'b0;
      if (!bus_timeout_enable || scl_i) begin // R6
        low_cnt_q <= 32'h0;
      end else if (low_cnt_q != BUS_LOW_CYC) begin
        low_cnt_q <= low_cnt_q + 32'h1;
        // fires once per low stretch
        bus_timeout_o <= (low_cnt_q == BUS_LOW_CYC - 1); // R7
      end
      if (!bus_timeout_enable || !(scl_i && sda_i)) begin // R6
        idle_cnt_q <= 32'h0;
      end else if (idle_cnt_q != BUS_IDLE_CYC) begin
        idle_cnt_q <= idle_cnt_q + 32'h1;
        bus_idle_reset_o <= (idle_cnt_q == BUS_IDLE_CYC - 1); // R7
      end
    end
  end

endmodule // touch_cfg_top

/* File: tb/host_model.sv */
// host side of the register port: single byte writes and reads
// assumes requests are taken on the rising edge; released lines carry junk
module host_model (
  input  wire       clk_i,
  output logic [7:0] addr_o,
  output logic       wr_o,
  output logic [7:0] wdata_o,
  output logic       rd_o,
  input  wire  [7:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    wdata_o = 8'h00;
    rd_o = 1'b0;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
endmodule // host_model

/* File: tb/touch_cfg_checker.sv */
// checker on the ports of the configuration block
// assumes bound to touch_cfg_top; shadows both registers from writes
module touch_cfg_checker #(
  parameter NCH          = 7,
  parameter BUS_LOW_CYC  = 100,
  parameter BUS_IDLE_CYC = 20
) (
  input wire             clk_i,
  input wire             reset_n_i,
  input wire [7:0]       reg_addr_i,
  input wire             reg_wr_i,
  input wire [7:0]       reg_wdata_i,
  input wire             reg_rd_i,
  input wire [7:0]       reg_rdata_o,
  input wire             scl_i,
  input wire             sda_i,
  input wire             bus_timeout_o,
  input wire             bus_idle_reset_o,
  input wire [NCH-1:0]   lf_noise_i,
  input wire [7:0]       touch_thr_i,
  input wire [NCH*8-1:0] delta_o,
  input wire [NCH-1:0]   touch_o,
  input wire [NCH-1:0]   recal_ok_o,
  input wire [15:0]      base_count_i,
  input wire [15:0]      base_view_o,
  input wire             button_irq_o,
  input wire             ungrouped_recal_o
);
  timeunit 1ns;
  timeprecision 1ps;
  reg  [7:0]  cfg_q, gain_q;
  reg  [31:0] low_q, idle_q;
  wire [3:0]  base_code = (gain_q[3:0] > 4'h8) ? 4'h8 : gain_q[3:0];
  wire        ana_kill  = lf_noise_i[0] & ~cfg_q[4];
  wire        any_touch = |touch_o;
  always @(posedge clk_i) begin
    low_q  <= (scl_i | ~cfg_q[7]) ? 32'h0 : low_q + 32'h1;
    idle_q <= (~(scl_i & sda_i) | ~cfg_q[7]) ? 32'h0 : idle_q + 32'h1;
    if (!reset_n_i) begin
      cfg_q  <= 8'h29;
      gain_q <= 8'h2f;
    end else if (reg_wr_i && reg_addr_i == 8'h20) begin
      cfg_q <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == 8'h1f) begin
      gain_q <= reg_wdata_i;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_gain_msb; reg_rd_i && reg_addr_i == 8'h1f |=> !reg_rdata_o[7]; endproperty
  a_gain_msb: assert property (p_gain_msb)
    else $error("gain register msb read as one");
  property p_tmo_off;
    !cfg_q[7] && !$past(cfg_q[7]) |-> !bus_timeout_o && !bus_idle_reset_o;
  endproperty
  a_tmo_off: assert property (p_tmo_off)
    else $error("bus pulse while timeout disabled");
  property p_tmo_len;
    bus_timeout_o |-> low_q >= BUS_LOW_CYC - 1 && low_q <= BUS_LOW_CYC + 2;
  endproperty
  a_tmo_len: assert property (p_tmo_len)
    else $error("clock low timeout at wrong count");
  property p_idle_len;
    bus_idle_reset_o |-> idle_q >= BUS_IDLE_CYC - 1 && idle_q <= BUS_IDLE_CYC + 2;
  endproperty
  a_idle_len: assert property (p_idle_len)
    else $error("idle reset at wrong count");
  property p_base;
    $past(reset_n_i) |-> base_view_o == ($past(base_count_i) >> $past(base_code));
  endproperty
  a_base: assert property (p_base)
    else $error("baseline view wrongly scaled");
  property p_ana_zero; $past(reset_n_i) && $past(ana_kill) |-> delta_o[7:0] == 8'h00; endproperty
  a_ana_zero: assert property (p_ana_zero)
    else $error("noisy channel delta not zero");
  property p_touch; touch_o[0] |-> !delta_o[7] && delta_o[7:0] > $past(touch_thr_i); endproperty
  a_touch: assert property (p_touch)
    else $error("touch without delta above threshold");
  property p_recal_ok; recal_ok_o[0] |-> !touch_o[0]; endproperty
  a_recal_ok: assert property (p_recal_ok)
    else $error("touched sample marked for recalibration");
  property p_no_hold; !cfg_q[3] && !$past(cfg_q[3]) |-> !ungrouped_recal_o; endproperty
  a_no_hold: assert property (p_no_hold)
    else $error("recalibration while hold recal disabled");
  property p_irq; $rose(any_touch) |-> ##[1:3] button_irq_o; endproperty
  a_irq: assert property (p_irq)
    else $error("no interrupt after touch");
endmodule // touch_cfg_checker

/* File: tb/testbench.sv */
// testbench: registers, delta path, bus timeout and hold timers
// assumes host_model for register access; timing parameters shortened
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam NCH = 7;
  logic clk_i, reset_n_i, reg_wr_i, reg_rd_i, scl_i, sda_i, group_press_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, touch_thr_i, noise_thr_i, rd_v, cfg;
  logic bus_timeout_o, bus_idle_reset_o, button_irq_o, group_irq_o;
  logic ungrouped_recal_o, grouped_recal_o;
  logic [NCH*16-1:0] raw_delta_i;
  logic [NCH-1:0] lf_noise_i, touch_o, recal_ok_o;
  logic [NCH*8-1:0] delta_o;
  logic [15:0] base_count_i, base_view_o;
  logic [6:0] slider_pos_i, slider_volume_o;
  logic [3:0] ungrouped_max_hold_time_i, grouped_max_hold_time_i, button_rate_i, group_rate_i;
  logic [3:0] b;
  logic [2:0] g;
  logic [9:0] e;
  int err_total, num_checks, n, m, j, k;

  touch_cfg_top #(.NCH(NCH), .CYC_PER_MS(10), .BUS_LOW_CYC(100), .BUS_IDLE_CYC(20)) DUT (.*);
  host_model host (.clk_i(clk_i), .addr_o(reg_addr_i), .wr_o(reg_wr_i),
    .wdata_o(reg_wdata_i), .rd_o(reg_rd_i), .rdata_i(reg_rdata_o));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // returns {recal_ok, touch, delta} for one channel
  function automatic logic [9:0] exp_ch(input logic signed [15:0] raw, input logic lf);
    logic signed [31:0] s;
    logic [7:0] d;
    logic t;
    s = raw;
    s = s <<< (7 - g);
    if (lf && !cfg[4]) s = 0;
    d = (s < 0) ? 8'hff : (s > 127) ? 8'h7f : s[7:0];
    t = !d[7] && d > touch_thr_i;
    return {!t && (cfg[5] || d[7] || d <= noise_thr_i), t, d};
  endfunction

  // waits for a bus pulse with the lines held as given
  task automatic bus_hold(input logic s, input logic d, output int cyc);
    @(negedge clk_i);
    scl_i = s;
    sda_i = d;
    cyc = 0;
    while (cyc < 150 && bus_timeout_o !== 1'b1 && bus_idle_reset_o !== 1'b1) begin
      @(negedge clk_i);
      cyc++;
    end
    scl_i = 1'b1;
    sda_i = 1'b1;
  endtask

  // press held 6000 cycles; counts interrupts and recalibrations
  task automatic hold_run(input logic [7:0] c, input int ni, input int nr);
    host.wr_reg(8'h20, c);
    raw_delta_i = {{((NCH-1)*16){1'b0}}, 16'h0100};
    group_press_i = 1'b1;
    {n, m, j, k} = 0;
    repeat (6000) begin
      @(negedge clk_i);
      n += (button_irq_o === 1'b1);
      m += (group_irq_o === 1'b1);
      j += (ungrouped_recal_o === 1'b1);
      k += (grouped_recal_o === 1'b1);
    end
    check("button_irq", n, ni);
    check("group_irq", m, ni);
    check("ungrouped_recal", j, nr);
    check("grouped_recal", k, nr);
    raw_delta_i = '0;
    group_press_i = 1'b0;
    repeat (20) @(negedge clk_i);
  endtask

  initial begin
    #300us;
    err_total++;
    close_out();
  end

  initial begin
    {reset_n_i, scl_i, sda_i, group_press_i} = 4'b0110;
    raw_delta_i = '0;
    {lf_noise_i, base_count_i, touch_thr_i, noise_thr_i} = '0;
    {ungrouped_max_hold_time_i, grouped_max_hold_time_i, button_rate_i, group_rate_i} = '0;
    void'($urandom(25651));
    slider_pos_i = 7'($urandom);
    repeat (16) @(negedge clk_i);
    reset_n_i = 1'b1;
    host.rd_reg(8'h1f, rd_v);
    check("gain_rst", rd_v, 8'h2f);
    host.rd_reg(8'h20, rd_v);
    check("cfg_rst", rd_v, 8'h29);
    host.rd_reg(8'h21, rd_v);
    check("unmapped", rd_v, 8'h00);
    host.wr_reg(8'h1f, 8'hff);
    host.rd_reg(8'h1f, rd_v);
    check("gain_msb", rd_v, 8'h7f);
    host.rd_reg(8'h06, rd_v);
    check("slider_pos", rd_v[6:0], slider_pos_i);
    host.wr_reg(8'h06, 8'h55);
    check("slider_ro", slider_volume_o, 7'h00);
    host.wr_reg(8'h20, 8'h40);
    host.wr_reg(8'h06, 8'h2a);
    check("slider_wr", slider_volume_o, 7'h2a);
    for (int i = 0; i < 40; i++) begin
      g = (i < 8) ? i[2:0] : 3'($urandom_range(0, 7));
      b = (i < 16) ? i[3:0] : 4'($urandom_range(0, 15));
      cfg = {2'b00, 2'($urandom_range(0, 3)), 4'h0};
      host.wr_reg(8'h1f, {1'b0, g, b});
      host.wr_reg(8'h20, cfg);
      for (int c = 0; c < NCH; c++) begin
        raw_delta_i[c*16+:16] = (c > 0 || i > 1) ? 16'($urandom_range(0, 600)) - 16'd300 :
                                (i == 0) ? 16'h8000 : 16'h7fff;
      end
      lf_noise_i = 7'($urandom);
      base_count_i = 16'($urandom);
      touch_thr_i = 8'($urandom_range(0, 126));
      noise_thr_i = 8'($urandom_range(0, 126));
      @(negedge clk_i);
      for (int c = 0; c < NCH; c++) begin
        e = exp_ch(raw_delta_i[c*16+:16], lf_noise_i[c]);
        check("delta", delta_o[c*8+:8], e[7:0]);
        check("touch", touch_o[c], e[8]);
        check("recal_ok", recal_ok_o[c], e[9]);
      end
      check("base_view", base_view_o, base_count_i >> ((b > 4'h8) ? 4'h8 : b));
    end
    {lf_noise_i, touch_thr_i} = {7'h00, 8'h10};
    // leftover touch would hide the first press of the hold runs
    raw_delta_i = '0;
    host.wr_reg(8'h20, 8'h00);
    bus_hold(1'b0, 1'b1, n);
    check("no_timeout", n, 150);
    host.wr_reg(8'h20, 8'h80);
    bus_hold(1'b1, 1'b0, n);
    bus_hold(1'b1, 1'b0, n);
    bus_hold(1'b1, 1'b1, n);
    check("idle_reset", n >= 19 && n <= 22, 1);
    bus_hold(1'b0, 1'b1, n);
    check("clock_low", n >= 99 && n <= 102, 1);
    hold_run(8'h0f, 18, 1);
    hold_run(8'h00, 1, 0);
    // rate code 1: repeat every 70 ms
    {button_rate_i, group_rate_i} = 8'h11;
    hold_run(8'h05, 9, 0);
    host.wr_reg(8'h1f, 8'h00);
    reset_n_i = 1'b0;
    repeat (4) @(negedge clk_i);
    reset_n_i = 1'b1;
    host.rd_reg(8'h1f, rd_v);
    check("gain_rerst", rd_v, 8'h2f);
    check("slider_rerst", slider_volume_o, 7'h00);
    close_out();
  end
endmodule // testbench

bind touch_cfg_top touch_cfg_checker #(.NCH(NCH), .BUS_LOW_CYC(BUS_LOW_CYC),
  .BUS_IDLE_CYC(BUS_IDLE_CYC)) mon (.*);
